// ==== logic/see_eeprom_slave.sv ====
// Two-wire serial EEPROM slave: bus front end, page buffer, array and write timer
// How it works
// - A start is SDA falling while SCL high; nothing is answered before one.
// - A stop is SDA rising while SCL high; it returns the device to idle.
// - SDA may only change while SCL is low, except start and stop.
// - Transmitter releases SDA after eight bits; receiver pulls it low on the ninth.
// - Acknowledge only after a start and a matching slave address.
// - When selected for write, acknowledge every further received byte.
// - In a read, sample the master acknowledge and send the next byte.
// - Without acknowledge after a read byte, stop sending; master then sends a stop.
// - Slave address top four bits are device type, next two match the straps.
// - Seventh address bit is the memory address top bit, giving 512 bytes.
// - Last address bit picks direction: one reads, zero writes.
// - Byte write is address, word address, one data byte; stop starts the write.
// - During the internal write cycle the bus inputs are ignored.
// - Page write takes up to sixteen data bytes before the stop.
// - Each page byte increments only the low four address bits.
// - More than sixteen bytes wrap within the page and overwrite earlier ones.
// - While busy the address is not acknowledged, allowing acknowledge polling.
// - Address counter holds last accessed location plus one for reads, plus one within the page for writes.
// - A matching read address is acknowledged, then the byte at the counter follows.
// - Random read is a dummy write of the word address, then a repeated start.
// - Sequential reads increment all address bits and wrap from the last to zero.
`timescale 1ns/1ps
module see_eeprom_slave
  import see_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic select_strap_low,
  input  wire logic select_strap_high,
  output logic      sda_out,
  output logic      sda_oe,
  output logic      write_busy
);

  logic [1:0]        rst_q;
  logic              rst_n;
  see_pins_t         pin_m;
  see_pins_t         pin_s;
  see_pins_t         pin_q;
  see_state_t        st;
  see_kind_t         kind;
  logic [3:0]        bitcnt;
  logic [7:0]        shreg;
  logic [8:0]        addr;
  logic              rw;
  logic              acked;
  logic [15:0]       pvalid;
  logic [BUSY_W-1:0] busy_cnt;
  logic [7:0]        mem [MEM_DEPTH];
  logic [7:0]        pbuf [PAGE_BYTES];
  logic              start_det;
  logic              stop_det;
  logic              bus_start;
  logic              bus_stop;
  logic              scl_rise;
  logic              scl_fall;
  logic              byte_done;
  logic              dev_match;
  logic [7:0]        rd_byte;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Two stages on every pin, then one more stage for edge finding
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_m <= PINS_RST;
      pin_s <= PINS_RST;
      pin_q <= PINS_RST;
    end else begin
      pin_m <= '{scl: scl_in, sda: sda_in, strap_hi: select_strap_high, strap_lo: select_strap_low};
      pin_s <= pin_m;
      pin_q <= pin_s;
    end
  end

  assign start_det = pin_s.scl & pin_q.scl & pin_q.sda & ~pin_s.sda;
  assign stop_det  = pin_s.scl & pin_q.scl & ~pin_q.sda & pin_s.sda;
  assign bus_start = start_det & ~write_busy;
  assign bus_stop  = stop_det & ~write_busy;
  assign scl_rise  = pin_s.scl & ~pin_q.scl;
  assign scl_fall  = ~pin_s.scl & pin_q.scl;
  assign byte_done = (st == ST_RX) && scl_fall && (bitcnt == BIT_LAST);
  assign dev_match = (shreg[7:4] == DEV_TYPE) && (shreg[3] == pin_s.strap_hi) && (shreg[2] == pin_s.strap_lo);
  assign rd_byte   = mem[addr];

  // Protocol engine; SDA is moved on SCL falling edges, and released at a start or stop
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st     <= ST_IDLE;
      kind   <= K_DEV;
      bitcnt <= BIT_ZERO;
      shreg  <= BYTE_RST;
      addr   <= ADDR_RST;
      rw     <= 1'b0;
      acked  <= 1'b0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      st     <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      // start (or repeated start) opens address reception
      st     <= ST_RX;
      kind   <= K_DEV;
      bitcnt <= BIT_ZERO;
      sda_oe <= 1'b0;
    end else begin
      case (st)
        ST_IDLE: begin
        end
        ST_RX: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], pin_s.sda};
            bitcnt <= bitcnt + BIT_ONE;
          end else if (byte_done) begin
            bitcnt <= BIT_ZERO;
            case (kind)
              K_DEV: begin
                if (dev_match) begin
                  // address top bit from slave address
                  addr[8] <= shreg[1];
                  rw      <= shreg[0];
                  st      <= ST_ACK;
                  sda_oe  <= 1'b1;
                end else begin
                  st <= ST_IDLE;
                end
              end
              K_WORD: begin
                // word address of a write or dummy write
                addr[7:0] <= shreg;
                st        <= ST_ACK;
                sda_oe    <= 1'b1;
              end
              K_DATA: begin
                // low nibble steps, top five bits stay
                addr[3:0] <= addr[3:0] + BIT_ONE;
                st        <= ST_ACK;
                sda_oe    <= 1'b1;
              end
              default: begin
                st <= ST_IDLE;
              end
            endcase
          end
        end
        ST_ACK: begin
          // hold low through the ninth clock; on its fall release, or drive the first read bit
          if (scl_fall) begin
            if (kind == K_DEV && rw) begin
              // first byte comes from the counter
              sda_oe <= ~rd_byte[7];
              shreg  <= {rd_byte[6:0], 1'b0};
              bitcnt <= BIT_ONE;
              addr   <= addr + 9'h001;
              st     <= ST_TX;
            end else begin
              sda_oe <= 1'b0;
              bitcnt <= BIT_ZERO;
              kind   <= (kind == K_DEV) ? K_WORD : K_DATA;
              st     <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bitcnt == BIT_LAST) begin
              // release SDA for the master acknowledge
              sda_oe <= 1'b0;
              st     <= ST_RACK;
            end else begin
              sda_oe <= ~shreg[7];
              shreg  <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + BIT_ONE;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            acked <= ~pin_s.sda;
          end else if (scl_fall) begin
            if (acked) begin
              // full nine-bit increment, wraps to zero
              sda_oe <= ~rd_byte[7];
              shreg  <= {rd_byte[6:0], 1'b0};
              bitcnt <= BIT_ONE;
              addr   <= addr + 9'h001;
              st     <= ST_TX;
            end else begin
              st <= ST_IDLE;
            end
          end
        end
        default: begin
          st     <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: the data level is always low, only the enable moves
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Pending page bytes; a start discards an uncommitted page so only a stop writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pvalid <= PVALID_RST;
    end else if (bus_stop || bus_start) begin
      pvalid <= PVALID_RST;
    end else if (byte_done && kind == K_DATA) begin
      // a wrapped index simply overwrites its slot
      pvalid[addr[3:0]] <= 1'b1;
    end
  end

  // Array and page buffer hold no reset; the array is nonvolatile by intent
  always_ff @(posedge core_clk) begin
    if (byte_done && kind == K_DATA) begin
      // up to sixteen bytes buffered per page
      pbuf[addr[3:0]] <= shreg;
    end
    if (bus_stop) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pvalid[i]) begin
          mem[{addr[8:4], 4'(i)}] <= pbuf[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_busy <= 1'b0;
      busy_cnt   <= '0;
    end else if (bus_stop && (|pvalid)) begin
      write_busy <= 1'b1;
      busy_cnt   <= BUSY_W'(WRITE_CYCLES_P - 1);
    end else if (write_busy) begin
      if (busy_cnt == '0) begin
        write_busy <= 1'b0;
      end else begin
        busy_cnt <= busy_cnt - 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  busy_quiet_a: assert property (write_busy |-> !sda_oe)
    else $error("SDA driven during write cycle");
  poll_nack_a: assert property (start_det && write_busy |=> st == $past(st) && !sda_oe)
    else $error("start taken while busy");
  stop_idle_a: assert property (bus_stop |=> st == ST_IDLE && !sda_oe)
    else $error("stop did not reach idle");
  start_rx_a: assert property (bus_start |=> st == ST_RX && kind == K_DEV && bitcnt == BIT_ZERO)
    else $error("start not taken");
  // enable moves only on SCL low edge or start and stop
  sda_timing_a: assert property ($changed(sda_oe) |-> $past(scl_fall || bus_stop || bus_start))
    else $error("SDA changed with SCL high");
  addr_ack_a: assert property (byte_done && kind == K_DEV && !bus_start && !bus_stop |=>
      sda_oe == $past(dev_match))
    else $error("address acknowledge wrong");
  // page increment stays inside the page
  page_wrap_a: assert property (byte_done && kind == K_DATA && !bus_start && !bus_stop |=>
      addr[3:0] == 4'($past(addr[3:0]) + 4'h1) && addr[8:4] == $past(addr[8:4]))
    else $error("page address step wrong");
  // read stream continues with full increment
  read_next_a: assert property (st == ST_RACK && scl_fall && acked && !bus_stop && !bus_start |=>
      st == ST_TX && addr == 9'($past(addr) + 9'h001))
    else $error("read stream not continued");
  nack_end_a: assert property (st == ST_RACK && scl_fall && !acked && !bus_stop && !bus_start |=>
      st == ST_IDLE && !sda_oe)
    else $error("read not ended after no acknowledge");
  // busy lasts at least eight cycles after it rises
  busy_hold_a: assert property ($rose(write_busy) |-> write_busy [*8])
    else $error("write cycle too short");
  write_ack_a: assert property (byte_done && kind != K_DEV && !bus_start && !bus_stop |=>
      st == ST_ACK && sda_oe)
    else $error("write byte not acknowledged");
  ack_release_a: assert property (st == ST_ACK && scl_fall && !(kind == K_DEV && rw) |=>
      st == ST_RX && !sda_oe)
    else $error("acknowledge not released");
  read_step_a: assert property (st == ST_ACK && scl_fall && kind == K_DEV && rw |=>
      st == ST_TX && addr == 9'($past(addr) + 9'h001))
    else $error("read counter not stepped");
  read_first_a: assert property (st == ST_ACK && scl_fall && kind == K_DEV && rw |=>
      sda_oe == !$past(rd_byte[7]))
    else $error("first read bit wrong");
  stop_write_a: assert property (bus_stop && (|pvalid) |=> write_busy)
    else $error("write cycle not started");
  stop_empty_a: assert property (bus_stop && !(|pvalid) |=> !write_busy)
    else $error("write cycle without data");
  busy_end_a: assert property (write_busy && busy_cnt == '0 |=> !write_busy)
    else $error("write cycle overran");

endmodule

// ==== include/see_pkg.sv ====
// Shared constants and types for the two-wire serial EEPROM slave
package see_pkg;
  localparam int       CLK_PERIOD_NS = 5;
  localparam int       WRITE_TIME_US = 5000;
  localparam int       WRITE_CYCLES  = WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int       MEM_DEPTH     = 512;
  localparam int       PAGE_BYTES    = 16;
  localparam int       BUSY_W        = 20;
  localparam logic [3:0] BIT_LAST    = 4'h8;
  localparam logic [3:0] BIT_ZERO    = 4'h0;
  localparam logic [3:0] BIT_ONE     = 4'h1;
  // Device type field; this value is arbitrary
  localparam logic [3:0] DEV_TYPE    = 4'h6;
  localparam logic [8:0] ADDR_RST    = 9'h000;
  localparam logic [7:0] BYTE_RST    = 8'h00;
  localparam logic [15:0] PVALID_RST = 16'h0000;

  typedef struct packed {
    logic scl;
    logic sda;
    logic strap_hi;
    logic strap_lo;
  } see_pins_t;

  localparam see_pins_t PINS_RST = '{scl: 1'b1, sda: 1'b1, strap_hi: 1'b0, strap_lo: 1'b0};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_RACK = 3'b100
  } see_state_t;

  typedef enum logic [1:0] {
    K_DEV  = 2'b00,
    K_WORD = 2'b01,
    K_DATA = 2'b10
  } see_kind_t;
endpackage

// ==== tb/see_master_model.sv ====
// Two-wire bus master model: drives the serial clock and pulls SDA low
`timescale 1ns/1ps
module see_master_model
  import see_pkg::*;
(
  output logic      scl,
  output logic      m_oe,
  input  wire logic sda
);
  localparam int QTR = 40;

  initial begin
    scl  = 1'b1;
    m_oe = 1'b0;
  end

  task automatic clk_bit(input logic b, output logic s);
    #QTR m_oe = ~b;
    #QTR scl = 1'b1;
    #QTR s = sda;
    #QTR scl = 1'b0;
  endtask

  task automatic start();
    if (scl === 1'b0) begin
      #QTR m_oe = 1'b0;
      #QTR scl = 1'b1;
    end
    #QTR m_oe = 1'b1;
    #QTR scl = 1'b0;
  endtask

  task automatic stop();
    #QTR m_oe = 1'b1;
    #QTR scl = 1'b1;
    #QTR m_oe = 1'b0;
    #QTR;
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic get_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(~more, s);
  endtask
endmodule

// ==== tb/test_see_eeprom_slave.sv ====
// Self-checking testbench for the two-wire EEPROM slave
`timescale 1ns/1ps
module test_see_eeprom_slave
  import see_pkg::*;
;
  // Short write cycle, still longer than one polling attempt
  localparam int WCYC = 1000;
  logic core_clk = 1'b0;
  logic arst_n   = 1'b0;
  logic strap_lo = 1'b0;
  logic strap_hi = 1'b1;
  logic scl;
  logic m_oe;
  logic sda_oe;
  logic sda_out;
  logic write_busy;
  wire logic sda;
  int n_fail = 0;
  int comparisons = 0;

  // Open-drain wire with pull-up
  assign sda = ~m_oe & (sda_oe ? sda_out : 1'b1);
  always #2.5 core_clk = ~core_clk;

  see_eeprom_slave #(.WRITE_CYCLES_P(WCYC)) DUT (
    .core_clk(core_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
    .select_strap_low(strap_lo), .select_strap_high(strap_hi),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_busy(write_busy));
  see_master_model mdl (.scl(scl), .m_oe(m_oe), .sda(sda));

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [7:0] sadr(input logic hi, input logic a8, input logic rw);
    return {DEV_TYPE, hi, 1'b0, a8, rw};
  endfunction

  task automatic addr_phase(input logic [8:0] a, input logic rw, output logic ack);
    mdl.start();
    mdl.put_byte(sadr(1'b1, a[8], rw), ack);
  endtask

  // Bounded wait for the internal write to finish
  task automatic wait_done();
    int n;
    // Keep the model's edges one step after the clock edge
    for (n = 0; n < 2 * WCYC && write_busy !== 1'b0; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (n == 2 * WCYC) begin
      n_fail++;
      $display("[ERR] write_busy expected 0 seen 1");
      wrap_up();
    end
  endtask

  task automatic t_select();
    logic ack;
    mdl.start();
    mdl.put_byte({~DEV_TYPE, 4'h8}, ack);
    check("ack wrong type", ack, 1'b0);
    mdl.put_byte(sadr(1'b1, 1'b0, 1'b0), ack);
    check("ack without start", ack, 1'b0);
    mdl.start();
    mdl.put_byte(sadr(1'b0, 1'b0, 1'b0), ack);
    check("ack wrong strap", ack, 1'b0);
    addr_phase(9'h000, 1'b0, ack);
    check("ack match", ack, 1'b1);
    mdl.stop();
    check("busy after empty write", write_busy, 1'b0);
    strap_lo = 1'b1;
    addr_phase(9'h000, 1'b0, ack);
    check("ack low strap moved", ack, 1'b0);
    mdl.start();
    mdl.put_byte({DEV_TYPE, 4'hC}, ack);
    check("ack both straps set", ack, 1'b1);
    mdl.stop();
    strap_lo = 1'b0;
    $display("select test done");
  endtask

  task automatic t_byte_write();
    logic ack;
    addr_phase(9'h1FF, 1'b0, ack);
    check("ack addr", ack, 1'b1);
    mdl.put_byte(8'hFF, ack);
    check("ack word", ack, 1'b1);
    mdl.put_byte(8'hA5, ack);
    check("ack data", ack, 1'b1);
    mdl.stop();
    check("busy after stop", write_busy, 1'b1);
    addr_phase(9'h1FF, 1'b0, ack);
    check("ack while busy", ack, 1'b0);
    mdl.stop();
    check("busy during poll", write_busy, 1'b1);
    wait_done();
    addr_phase(9'h1FF, 1'b0, ack);
    check("ack after write", ack, 1'b1);
    mdl.stop();
    $display("byte write test done");
  endtask

  task automatic t_page();
    logic ack;
    logic [7:0] d;
    addr_phase(9'h00E, 1'b0, ack);
    mdl.put_byte(8'h0E, ack);
    for (int i = 0; i < 18; i++) begin
      mdl.put_byte(8'(8'h40 + i), ack);
      check("ack page byte", ack, 1'b1);
    end
    mdl.stop();
    wait_done();
    mdl.start();
    mdl.put_byte(sadr(1'b1, 1'b0, 1'b1), ack);
    check("ack read", ack, 1'b1);
    for (int n = 0; n < 16; n++) begin
      mdl.get_byte(n < 15, d);
      check("page data", d, 8'(8'h42 + n));
    end
    #100;
    check("released after nack", sda_oe, 1'b0);
    check("open drain level", sda_out, 1'b0);
    mdl.stop();
    $display("page test done");
  endtask

  task automatic t_wrap();
    logic ack;
    logic [7:0] d;
    addr_phase(9'h1FF, 1'b0, ack);
    mdl.put_byte(8'hFF, ack);
    addr_phase(9'h1FF, 1'b1, ack);
    check("ack random read", ack, 1'b1);
    mdl.get_byte(1'b1, d);
    check("top byte", d, 8'hA5);
    mdl.get_byte(1'b0, d);
    check("wrapped byte", d, 8'h42);
    mdl.stop();
    $display("wrap test done");
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    #1 arst_n = 1'b1;
    repeat (8) @(posedge core_clk);
    #1;
    t_select();
    t_byte_write();
    t_page();
    t_wrap();
    wrap_up();
  end
endmodule
